// ===== logic/lane_config_override_regs.sv
/*
 Register bank that overrides lane identifiers and checksums of link lanes 1 to 4,
 and fixes or frees the link version and subclass, reached over Avalon-MM.
 Assumes one clock, a master that holds its request until waitrequest is low,
 and a checksum generator outside that supplies the computed value per lane.
*/
`timescale 1ns/100ps
`default_nettype none

`include "lane_cfg_consts.svh"

module lane_config_override_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire lane_cfg_pkg::addr_type avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire lane_cfg_pkg::data_type avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output lane_cfg_pkg::data_type avs_readdata,
   output lane_cfg_pkg::resp_type avs_response,
   output logic avs_waitrequest,
   input wire lane_cfg_pkg::sum_type computed_sum_lane1,
   input wire lane_cfg_pkg::sum_type computed_sum_lane2,
   input wire lane_cfg_pkg::sum_type computed_sum_lane3,
   input wire lane_cfg_pkg::sum_type computed_sum_lane4,
   output lane_cfg_pkg::ident_type lane_ident_lane1,
   output lane_cfg_pkg::ident_type lane_ident_lane2,
   output lane_cfg_pkg::ident_type lane_ident_lane3,
   output lane_cfg_pkg::ident_type lane_ident_lane4,
   output lane_cfg_pkg::sum_type lane_sum_lane1,
   output lane_cfg_pkg::sum_type lane_sum_lane2,
   output lane_cfg_pkg::sum_type lane_sum_lane3,
   output lane_cfg_pkg::sum_type lane_sum_lane4,
   output logic link_rev_b,
   output logic [1:0] link_subclass,
   output logic link_sel_invalid
);
   import lane_cfg_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Byte of a lane pair register: even lane upper byte, odd lane lower
   function automatic sum_type lane_half(input reg16_type r, input logic odd);
      lane_half = odd ? r[7:0] : r[15:8];
   endfunction

   // Identifier of a lane pair register: even lane bits 12:8, odd lane bits 4:0
   function automatic ident_type lane_ident(input reg16_type r, input logic odd);
      lane_ident = odd ? r[4:0] : r[12:8];
   endfunction

   // Byte-lane merge of a 16-bit register write
   function automatic reg16_type merge16(input reg16_type old, input reg16_type wd,
                                         input logic [1:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   // ----------------------------------------------------------------
   // State and decode
   // ----------------------------------------------------------------
   regs_state_type s_q;
   regs_state_type s_d;
   logic [`IDX_W-1:0] idx;
   logic aligned;
   logic mapped;
   logic request;
   reg16_type sel_word;
   sum_type computed [`LANES];
   ident_type default_ident [`LANES];
   ident_type pick_ident [`LANES];
   sum_type pick_sum [`LANES];
   logic [2:0] rev_code;
   logic [2:0] sub_code;

   // Address split into word index and alignment check
   assign idx = avs_address[`BUS_ADDR_W-1:2];
   assign aligned = (avs_address[1:0] == 2'h0);
   assign request = avs_read | avs_write;

   // Read mux over the mapped words
   always_comb begin
      mapped = aligned;
      case (idx)
         `IDX_OVR_CTRL: sel_word = s_q.ctrl;
         `IDX_SUM_12: sel_word = s_q.sum12;
         `IDX_SUM_34: sel_word = s_q.sum34;
         `IDX_IDENT_12: sel_word = s_q.id12;
         `IDX_IDENT_34: sel_word = s_q.id34;
         `IDX_STD_SEL: sel_word = s_q.stdsel;
         default: begin
            sel_word = `REG_RESET;
            mapped = 1'b0;
         end
      endcase
   end

   // Inputs and defaults gathered per lane
   assign computed[0] = computed_sum_lane1;
   assign computed[1] = computed_sum_lane2;
   assign computed[2] = computed_sum_lane3;
   assign computed[3] = computed_sum_lane4;
   assign default_ident[0] = `DEF_IDENT_LANE1;
   assign default_ident[1] = `DEF_IDENT_LANE2;
   assign default_ident[2] = `DEF_IDENT_LANE3;
   assign default_ident[3] = `DEF_IDENT_LANE4;

   // ----------------------------------------------------------------
   // Lane sources
   // ----------------------------------------------------------------
   // enable bits from the MSB down in ascending lane order
   for (genvar n = 0; n < `LANES; n++) begin : g_lane
      lane_source_pick u_pick (
         .ident_en(s_q.ctrl[`ID_EN_MSB - n]),
         .sum_en(s_q.ctrl[`SUM_EN_MSB - n]),
         .forced_ident(lane_ident((n < 2) ? s_q.id12 : s_q.id34, (n % 2) == 1)),
         .default_ident(default_ident[n]),
         .forced_sum(lane_half((n < 2) ? s_q.sum12 : s_q.sum34, (n % 2) == 1)),
         .computed_sum(computed[n]),
         .ident(pick_ident[n]),
         .sum(pick_sum[n])
      );
   end

   assign rev_code = s_q.stdsel[`REVISION_MSB:`REVISION_LSB];
   assign sub_code = s_q.stdsel[`SUBCLASS_MSB:`SUBCLASS_LSB];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      for (int n = 0; n < `LANES; n++) begin
         s_d.ident[n] = pick_ident[n];
         s_d.sum[n] = pick_sum[n];
      end
      s_d.rev_b = 1'b1;
      s_d.subclass = `SUBCLASS_1;
      s_d.sel_invalid = 1'b0;
      if (s_q.ctrl[`REV_SEL_EN_BIT]) begin
         case (rev_code)
            `REV_A_CODE: s_d.rev_b = 1'b0;
            `REV_B_CODE: s_d.rev_b = 1'b1;
            default: s_d.sel_invalid = 1'b1;
         endcase
         case (sub_code)
            `SUBCLASS_CODE_0: s_d.subclass = `SUBCLASS_0;
            `SUBCLASS_CODE_1: s_d.subclass = `SUBCLASS_1;
            `SUBCLASS_CODE_2: s_d.subclass = `SUBCLASS_2;
            default: s_d.sel_invalid = 1'b1;
         endcase
         // Undefined codes fall back to the fixed mode
         if (s_d.sel_invalid) begin
            s_d.rev_b = 1'b1;
            s_d.subclass = `SUBCLASS_1;
         end
      end
      // Avalon slave: one wait cycle, then answer
      case (s_q.state)
         bus_idle: begin
            if (request) begin
               s_d.state = bus_answer;
               s_d.rdata = {16'h0000, sel_word};
               s_d.resp = mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
         end
         bus_answer: begin
            s_d.state = bus_idle;
            if (avs_write && mapped) begin
               case (idx)
                  `IDX_OVR_CTRL: s_d.ctrl = merge16(s_q.ctrl, avs_writedata[15:0],
                                                    avs_byteenable[1:0]);
                  `IDX_SUM_12: s_d.sum12 = merge16(s_q.sum12, avs_writedata[15:0],
                                                   avs_byteenable[1:0]);
                  `IDX_SUM_34: s_d.sum34 = merge16(s_q.sum34, avs_writedata[15:0],
                                                   avs_byteenable[1:0]);
                  `IDX_IDENT_12: s_d.id12 = merge16(s_q.id12, avs_writedata[15:0],
                                                    avs_byteenable[1:0]);
                  `IDX_IDENT_34: s_d.id34 = merge16(s_q.id34, avs_writedata[15:0],
                                                    avs_byteenable[1:0]);
                  `IDX_STD_SEL: s_d.stdsel = merge16(s_q.stdsel, avs_writedata[15:0],
                                                     avs_byteenable[1:0]);
                  default: s_d.ctrl = s_q.ctrl;
               endcase
            end
         end
         default: s_d.state = bus_idle;
      endcase
   end

   // state register, all fields zero at reset except rev_b and subclass (version B, subclass 1)
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.state <= bus_idle;
         s_q.rev_b <= 1'b1;
         s_q.subclass <= `SUBCLASS_1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Waitrequest drops in the answer cycle only
   assign avs_waitrequest = request && (s_q.state != bus_answer);
   assign avs_readdata = s_q.rdata;
   assign avs_response = s_q.resp;
   assign lane_ident_lane1 = s_q.ident[0];
   assign lane_ident_lane2 = s_q.ident[1];
   assign lane_ident_lane3 = s_q.ident[2];
   assign lane_ident_lane4 = s_q.ident[3];
   assign lane_sum_lane1 = s_q.sum[0];
   assign lane_sum_lane2 = s_q.sum[1];
   assign lane_sum_lane3 = s_q.sum[2];
   assign lane_sum_lane4 = s_q.sum[3];
   assign link_rev_b = s_q.rev_b;
   assign link_subclass = s_q.subclass;
   assign link_sel_invalid = s_q.sel_invalid;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_default_ident_low: assert property (@(posedge mclk) disable iff (rst)
      !s_q.ctrl[`ID_EN_MSB] && !s_q.ctrl[`ID_EN_MSB - 1] |=>
      lane_ident_lane1 == `DEF_IDENT_LANE1 && lane_ident_lane2 == `DEF_IDENT_LANE2)
      else $error("default identifier of lane 1 or 2 wrong");

   a_default_ident_high: assert property (@(posedge mclk) disable iff (rst)
      !s_q.ctrl[`ID_EN_MSB - 2] && !s_q.ctrl[`ID_EN_MSB - 3] |=>
      lane_ident_lane3 == `DEF_IDENT_LANE3 && lane_ident_lane4 == `DEF_IDENT_LANE4)
      else $error("default identifier of lane 3 or 4 wrong");

   a_forced_ident_one: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`ID_EN_MSB] |=> lane_ident_lane1 == $past(s_q.id12[12:8]))
      else $error("lane 1 forced identifier not sent");

   a_ident_en_four: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`ID_EN_MSB - 3] && !s_q.ctrl[`ID_EN_MSB] |=>
      lane_ident_lane4 == $past(s_q.id34[4:0]) && lane_ident_lane1 == `DEF_IDENT_LANE1)
      else $error("lane 4 identifier enable misplaced");

   a_computed_sum_pass: assert property (@(posedge mclk) disable iff (rst)
      !s_q.ctrl[`SUM_EN_MSB - 3] |=> lane_sum_lane4 == $past(computed_sum_lane4))
      else $error("lane 4 computed checksum not passed");

   a_forced_sum_one: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`SUM_EN_MSB] |=> lane_sum_lane1 == $past(s_q.sum12[15:8]))
      else $error("lane 1 forced checksum not sent");

   a_ident_pair_two: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`ID_EN_MSB - 1] |=> lane_ident_lane2 == $past(s_q.id12[4:0]))
      else $error("lane 2 identifier taken from wrong byte");

   a_sum_pair_three: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`SUM_EN_MSB - 2] |=> lane_sum_lane3 == $past(s_q.sum34[15:8]))
      else $error("lane 3 checksum taken from wrong byte");

   a_fixed_rev_b: assert property (@(posedge mclk) disable iff (rst)
      !s_q.ctrl[`REV_SEL_EN_BIT] |=> link_rev_b && link_subclass == `SUBCLASS_1)
      else $error("fixed mode not version B subclass 1");

   a_selected_rev_a: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`REV_SEL_EN_BIT] && rev_code == `REV_A_CODE && sub_code == `SUBCLASS_CODE_2
      |=> !link_rev_b && link_subclass == `SUBCLASS_2 && !link_sel_invalid)
      else $error("selected version and subclass not applied");

   a_write_readback: assert property (@(posedge mclk) disable iff (rst)
      avs_write && !avs_waitrequest && aligned && idx == `IDX_SUM_34
      && avs_byteenable[1:0] == 2'h3 |=> s_q.sum34 == $past(avs_writedata[15:0]))
      else $error("written word not stored");

   a_bus_one_wait: assert property (@(posedge mclk) disable iff (rst)
      request && avs_waitrequest |=> !avs_waitrequest ##1 (!request || avs_waitrequest))
      else $error("slave answer not after exactly one wait cycle");

   a_forced_ident_three: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`ID_EN_MSB - 2] |=> lane_ident_lane3 == $past(s_q.id34[12:8]))
      else $error("lane 3 forced identifier not sent");

   a_ident_en_two: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`ID_EN_MSB - 1] && !s_q.ctrl[`ID_EN_MSB - 2] |=>
      lane_ident_lane2 == $past(s_q.id12[4:0]) && lane_ident_lane3 == `DEF_IDENT_LANE3)
      else $error("lane 2 identifier enable misplaced");

   a_computed_sum_one: assert property (@(posedge mclk) disable iff (rst)
      !s_q.ctrl[`SUM_EN_MSB] |=> lane_sum_lane1 == $past(computed_sum_lane1))
      else $error("lane 1 computed checksum not passed");

   a_forced_sum_two: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`SUM_EN_MSB - 1] |=> lane_sum_lane2 == $past(s_q.sum12[7:0]))
      else $error("lane 2 forced checksum not sent");

   a_sum_pair_four: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`SUM_EN_MSB - 3] |=> lane_sum_lane4 == $past(s_q.sum34[7:0]))
      else $error("lane 4 checksum taken from wrong byte");

   a_bad_code_fallback: assert property (@(posedge mclk) disable iff (rst)
      s_q.ctrl[`REV_SEL_EN_BIT] && (rev_code > `REV_B_CODE || sub_code > `SUBCLASS_CODE_2)
      |=> link_sel_invalid && link_rev_b && link_subclass == `SUBCLASS_1)
      else $error("undefined selection code not flagged");

   a_refused_write: assert property (@(posedge mclk) disable iff (rst)
      avs_write && !avs_waitrequest && !mapped |=>
      s_q.sum12 == $past(s_q.sum12) && s_q.ctrl == $past(s_q.ctrl))
      else $error("refused write changed a register");

   a_error_response: assert property (@(posedge mclk) disable iff (rst)
      request && avs_waitrequest && !mapped |=> avs_response == `RESP_SLVERR)
      else $error("refused access not answered with error");

endmodule // lane_config_override_regs

`default_nettype wire

// ===== inc/lane_cfg_consts.svh
/*
 Offsets, field positions, reset values and codes of the lane override register bank.
 Assumes it is included by bare name from the package and the design files.
*/
`ifndef LANE_CFG_CONSTS_SVH
`define LANE_CFG_CONSTS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define BUS_ADDR_W 9
`define BUS_DATA_W 32
`define REG_W 16
`define IDX_W 7

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_OVR_CTRL 7'h73
`define IDX_SUM_12 7'h74
`define IDX_SUM_34 7'h75
`define IDX_IDENT_12 7'h76
`define IDX_IDENT_34 7'h77
`define IDX_STD_SEL 7'h55
`define REG_RESET 16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ID_EN_MSB 15
`define SUM_EN_MSB 11
`define REV_SEL_EN_BIT 4
`define SUBCLASS_MSB 15
`define SUBCLASS_LSB 13
`define REVISION_MSB 7
`define REVISION_LSB 5
`define IDENT_W 5
`define SUM_W 8
`define LANES 4

// ----------------------------------------------------------------
// Default identifiers and link codes
// ----------------------------------------------------------------
`define DEF_IDENT_LANE1 5'h01
`define DEF_IDENT_LANE2 5'h02
`define DEF_IDENT_LANE3 5'h03
`define DEF_IDENT_LANE4 5'h04
`define SUBCLASS_CODE_0 3'h0
`define SUBCLASS_CODE_1 3'h1
`define SUBCLASS_CODE_2 3'h2
`define REV_A_CODE 3'h0
`define REV_B_CODE 3'h1
`define SUBCLASS_0 2'h0
`define SUBCLASS_1 2'h1
`define SUBCLASS_2 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== inc/lane_cfg_pkg.sv
/*
 Types of the lane override register bank: bus states and the packed state record.
 Assumes the constants header is on the include path.
*/
`default_nettype none
`include "lane_cfg_consts.svh"

package lane_cfg_pkg;

   // ----------------------------------------------------------------
   // Field types
   // ----------------------------------------------------------------
   typedef logic [`IDENT_W-1:0] ident_type;
   typedef logic [`SUM_W-1:0] sum_type;
   typedef logic [`REG_W-1:0] reg16_type;
   typedef logic [`BUS_ADDR_W-1:0] addr_type;
   typedef logic [`BUS_DATA_W-1:0] data_type;
   typedef logic [1:0] resp_type;

   // Slave handshake states
   typedef enum logic {bus_idle, bus_answer} bus_state_type;

   // ----------------------------------------------------------------
   // Whole state of the register bank
   // ----------------------------------------------------------------
   typedef struct packed {
      bus_state_type state;
      reg16_type ctrl;
      reg16_type sum12;
      reg16_type sum34;
      reg16_type id12;
      reg16_type id34;
      reg16_type stdsel;
      data_type rdata;
      resp_type resp;
      logic [`LANES-1:0][`IDENT_W-1:0] ident;
      logic [`LANES-1:0][`SUM_W-1:0] sum;
      logic rev_b;
      logic [1:0] subclass;
      logic sel_invalid;
   } regs_state_type;

endpackage

`default_nettype wire

// ===== logic/lane_source_pick.sv
/*
 Per-lane choice between forced and default identifier and between forced and computed checksum.
 Assumes the parent registers the chosen values.
*/
`timescale 1ns/100ps
`default_nettype none

module lane_source_pick (
   input wire logic ident_en,
   input wire logic sum_en,
   input wire lane_cfg_pkg::ident_type forced_ident,
   input wire lane_cfg_pkg::ident_type default_ident,
   input wire lane_cfg_pkg::sum_type forced_sum,
   input wire lane_cfg_pkg::sum_type computed_sum,
   output lane_cfg_pkg::ident_type ident,
   output lane_cfg_pkg::sum_type sum
);
   import lane_cfg_pkg::*;

   assign ident = ident_en ? forced_ident : default_ident;
   assign sum = sum_en ? forced_sum : computed_sum;

endmodule // lane_source_pick

`default_nettype wire

// ===== bench/test_lane_config_override_regs.sv
/*
 Self-checking bench of the lane override register bank: register access, lane outputs,
 link version and subclass selection, reset.
 Assumes the package and the constants header are compiled and on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lane_cfg_consts.svh"

module test_lane_config_override_regs;
   import lane_cfg_pkg::*;

   // ----------------------------------------------------------------
   // Signals and design
   // ----------------------------------------------------------------
   localparam addr_type A_CTRL = {`IDX_OVR_CTRL, 2'b00};
   localparam addr_type A_S12 = {`IDX_SUM_12, 2'b00};
   localparam addr_type A_S34 = {`IDX_SUM_34, 2'b00};
   localparam addr_type A_I12 = {`IDX_IDENT_12, 2'b00};
   localparam addr_type A_I34 = {`IDX_IDENT_34, 2'b00};
   localparam addr_type A_STD = {`IDX_STD_SEL, 2'b00};
   typedef struct packed {
      addr_type a;
      data_type w;
      logic [3:0] be;
      data_type r;
      resp_type rsp;
   } row_type;
   // Write then read back; the last two are refused places
   localparam row_type rows [9] = '{
      '{A_S12, 32'h0000A5C3, 4'hF, 32'h0000A5C3, `RESP_OKAY},
      '{A_S34, 32'hFFFF3C96, 4'h3, 32'h00003C96, `RESP_OKAY},
      '{A_S34, 32'h000011FF, 4'h1, 32'h00003CFF, `RESP_OKAY},
      '{A_S12, 32'h00007700, 4'h2, 32'h000077C3, `RESP_OKAY},
      '{A_I12, 32'h00001109, 4'h3, 32'h00001109, `RESP_OKAY},
      '{A_I34, 32'h0000E7E2, 4'h3, 32'h0000E7E2, `RESP_OKAY},
      '{A_STD, 32'h00002020, 4'h3, 32'h00002020, `RESP_OKAY},
      '{9'h1E0, 32'h00001234, 4'h3, 32'h00000000, `RESP_SLVERR},
      '{9'h1D2, 32'h00005555, 4'h3, 32'h000077C3, `RESP_SLVERR}};
   localparam addr_type regs_a [6] = '{A_CTRL, A_S12, A_S34, A_I12, A_I34, A_STD};
   logic mclk = 1'b0;
   logic rst = 1'b1;
   addr_type avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   data_type avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'h0;
   data_type avs_readdata;
   resp_type avs_response;
   logic avs_waitrequest;
   sum_type comp [4] = '{8'h21, 8'h42, 8'h63, 8'h84};
   ident_type id_o [4];
   sum_type sum_o [4];
   logic link_rev_b;
   logic [1:0] link_subclass;
   logic link_sel_invalid;
   int failures = 0;
   int check_count = 0;
   data_type rd;
   resp_type rs;
   ident_type fid [4] = '{5'h11, 5'h09, 5'h07, 5'h02};
   sum_type fsum [4] = '{8'h77, 8'hC3, 8'h3C, 8'hFF};

   lane_config_override_regs uut (
      .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
      .computed_sum_lane1(comp[0]), .computed_sum_lane2(comp[1]),
      .computed_sum_lane3(comp[2]), .computed_sum_lane4(comp[3]),
      .lane_ident_lane1(id_o[0]), .lane_ident_lane2(id_o[1]),
      .lane_ident_lane3(id_o[2]), .lane_ident_lane4(id_o[3]),
      .lane_sum_lane1(sum_o[0]), .lane_sum_lane2(sum_o[1]),
      .lane_sum_lane3(sum_o[2]), .lane_sum_lane4(sum_o[3]),
      .link_rev_b(link_rev_b), .link_subclass(link_subclass),
      .link_sel_invalid(link_sel_invalid));

   // Clock of 40 ns
   always #20 mclk = ~mclk;

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One bus request, held until waitrequest is seen low
   task automatic bus(input logic wr, input addr_type a, input data_type d,
                      input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge mclk);
      end
      if (n >= 20) failures++;
      rd = avs_readdata;
      rs = avs_response;
   endtask

   task automatic idle;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask

   // Write, then let the lane outputs follow
   task automatic wreg(input addr_type a, input data_type d);
      bus(1'b1, a, d, 4'hF);
      idle();
      @(posedge mclk);
   endtask

   task automatic rreg(input addr_type a);
      bus(1'b0, a, '0, 4'hF);
   endtask

   // Per-lane enables, bit 0 is lane 1; computed sums move meanwhile
   task automatic check_lanes(input logic [3:0] ie, input logic [3:0] se);
      data_type c;
      c = {16'h0, ie[0], ie[1], ie[2], ie[3], se[0], se[1], se[2], se[3], 8'h00};
      for (int i = 0; i < 4; i++) comp[i] <= comp[i] ^ 8'h5A;
      wreg(A_CTRL, c);
      rreg(A_CTRL);
      check(rd, c);
      for (int i = 0; i < 4; i++) begin
         check(id_o[i], ie[i] ? fid[i] : 5'(i + 1));
         check(sum_o[i], se[i] ? fsum[i] : comp[i]);
      end
   endtask

   task automatic check_ver(input data_type s, input logic en, input logic b,
                            input logic [1:0] sc, input logic inv);
      wreg(A_STD, s);
      wreg(A_CTRL, {27'h0, en, 4'h0});
      check(link_rev_b, b);
      check(link_subclass, sc);
      check(link_sel_invalid, inv);
   endtask

   task automatic finish_test;
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   // Watchdog well beyond the expected run
   initial begin
      repeat (4000) @(posedge mclk);
      failures++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         rreg(regs_a[i]);
         check(rd, 32'h0);
         check(rs, `RESP_OKAY);
      end
      for (int i = 0; i < 4; i++) begin
         check(id_o[i], 5'(i + 1));
         check(sum_o[i], comp[i]);
      end
      check(link_rev_b, 1'b1);
      check(link_subclass, 2'h1);
      // Table of writes each followed at once by its read
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, rows[i].a, rows[i].w, rows[i].be);
         bus(1'b0, rows[i].a, '0, 4'hF);
         check(rd, rows[i].r);
         check(rs, rows[i].rsp);
      end
      rreg(A_S12);
      check(rd, 32'h000077C3);
      check_lanes(4'h0, 4'h0);
      for (int i = 0; i < 4; i++) check_lanes(4'h1 << i, 4'h1 << i);
      check_lanes(4'hF, 4'h0);
      check_lanes(4'h0, 4'hF);
      check_ver(32'h0000, 1'b0, 1'b1, 2'h1, 1'b0);
      check_ver(32'h0000, 1'b1, 1'b0, 2'h0, 1'b0);
      check_ver(32'h2020, 1'b1, 1'b1, 2'h1, 1'b0);
      check_ver(32'h4000, 1'b1, 1'b0, 2'h2, 1'b0);
      check_ver(32'h6020, 1'b1, 1'b1, 2'h1, 1'b1);
      check_ver(32'h0040, 1'b1, 1'b1, 2'h1, 1'b1);
      check_ver(32'h4000, 1'b0, 1'b1, 2'h1, 1'b0);
      // Second reset in mid-run with overrides set
      wreg(A_CTRL, 32'h0000FF10);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rreg(A_CTRL);
      check(rd, 32'h0);
      rreg(A_I12);
      check(rd, 32'h0);
      for (int i = 0; i < 4; i++) check(id_o[i], 5'(i + 1));
      check(link_rev_b, 1'b1);
      finish_test();
   end
endmodule // test_lane_config_override_regs

`default_nettype wire
